/* File: src/rcm_pkg.sv */
// Purpose: Shared constants and types of the reset, clock and mode control block
// Assumes: 100 MHz control clock, 32-bit register port with byte offsets
// Notes: Every offset, flag position and timing count lives here, with the control bit positions and the flag, ROM, bus and RTC reset values
package rcm_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned RST_HOLD_NS = 100;
  localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] RST_HOLD_LOAD = 4'(RST_HOLD_CYC - 1);

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_RST_STATUS_0 = 8'h00;
  localparam logic [7:0] OFS_RST_STATUS_1 = 8'h04;
  localparam logic [7:0] OFS_RST_STATUS_2 = 8'h08;
  localparam logic [7:0] OFS_SYS_CTRL_0 = 8'h0C;
  localparam logic [7:0] OFS_CLK_SELECT = 8'h10;
  localparam logic [7:0] OFS_MODE_STATUS = 8'h14;
  localparam logic [7:0] OFS_SW_RESET = 8'h18;
  localparam logic [7:0] OFS_RTC_KEEP = 8'h1C;

  // ****************************************
  // Reset detection flag positions
  // ****************************************
  localparam int unsigned NUM_SRC = 8;
  localparam int unsigned FLG_POWER_ON = 0;
  localparam int unsigned FLG_VMON0 = 1;
  localparam int unsigned FLG_VMON1 = 2;
  localparam int unsigned FLG_VMON2 = 3;
  localparam int unsigned FLG_INDEP_WDOG = 4;
  localparam int unsigned FLG_WDOG = 5;
  localparam int unsigned FLG_SOFTWARE = 6;
  localparam int unsigned FLG_EXT_PIN = 7;
  localparam logic [7:0] FLAGS_RST_VAL = 8'h01;
  localparam logic [7:0] FLAGS_PIN_KEEP = 8'h80;

  // ****************************************
  // Control field positions and reset values
  // ****************************************
  localparam int unsigned SC0_ROM_EN_BIT = 0;
  localparam int unsigned SC0_EXT_BUS_BIT = 1;
  localparam int unsigned STS1_WARM_BIT = 0;
  localparam int unsigned SWR_TRIGGER_BIT = 0;
  localparam logic ROM_EN_RST = 1'b1;
  localparam logic EXT_BUS_RST = 1'b0;
  localparam logic [31:0] RTC_KEEP_RST = 32'h0000_0000;

  // ****************************************
  // Address map used in ROM-disabled extended mode
  // ****************************************
  localparam logic [31:0] MAP_RAM_END = 32'h0001_0000;
  localparam logic [31:0] MAP_PERIPH_BASE = 32'h0008_0000;
  localparam logic [31:0] MAP_PERIPH_END = 32'h0010_0000;
  localparam logic [31:0] MAP_CS_BASE = 32'h0500_0000;
  localparam logic [31:0] MAP_RESV_BASE = 32'h0800_0000;

  typedef enum logic [2:0] {
    CLK_LOW_INT_OSC, CLK_HIGH_INT_OSC, CLK_MAIN_OSC, CLK_SUB_OSC,
    CLK_PLL, CLK_USB_PLL, CLK_INDEP_WDOG_OSC
  } rcm_clk_src_t;

  typedef enum logic [1:0] {MODE_ROM_OFF_NO_EXT, MODE_SINGLE_CHIP, MODE_ROM_OFF_EXT, MODE_ROM_ON_EXT} rcm_op_mode_t;

  typedef enum logic [2:0] {
    REG_NONE, REG_RAM, REG_PERIPH, REG_CS_EXT, REG_RESERVED
  } rcm_region_t;

endpackage : rcm_pkg

/* File: src/rcm_flag_if.sv */
// Purpose: Carrier between the sequencer and the detection flag bank
// Assumes: Same clock on both ends
// Notes: Clear strobes are one cycle long; set and pin-reset are levels held while their source is active
`timescale 1ns/1ps
interface rcm_flag_if;
  import rcm_pkg::*;
  logic [NUM_SRC-1:0] set;   // Source seen
  logic [NUM_SRC-1:0] clr;   // Software clear
  logic pin_init;            // External pin reset in progress
  logic [NUM_SRC-1:0] flags; // Current flags
  modport bank (input set, input clr, input pin_init, output flags);
  modport ctrl (output set, output clr, output pin_init, input flags);
endinterface : rcm_flag_if

/* File: src/rcm_flag_bank.sv */
// Purpose: Sticky reset detection flags, one per source
// Assumes: RSTN is the power-on reset
// Notes: A set in the same cycle as a clear or a pin init wins
`timescale 1ns/1ps
module rcm_flag_bank
  import rcm_pkg::*;
(
  input wire logic CLK,    // Control clock
  input wire logic RSTN,   // Power-on reset, active low
  input wire logic CE,     // Clock enable
  rcm_flag_if.bank fl      // Flag strobes and state
);

  logic [NUM_SRC-1:0] flag_q;
  logic [NUM_SRC-1:0] flag_d;

  // ****************************************
  // Per-source flag
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : g_flag
      // Pin reset wipes every flag except its own; sets still win
      always_comb
      begin
        flag_d[g] = flag_q[g];
        if (fl.clr[g] || (fl.pin_init && !FLAGS_PIN_KEEP[g]))
          flag_d[g] = 1'b0;
        if (fl.set[g])
          flag_d[g] = 1'b1;
      end
    end
  endgenerate

  // Flags survive every reset but power-on; a pin reset clears all but its own
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      flag_q <= FLAGS_RST_VAL;
    else if (CE)
      flag_q <= flag_d;
  end

  assign fl.flags = flag_q;

endmodule : rcm_flag_bank

/* File: src/rcm_ctrl.sv */
// Purpose: Reset merge, clock source and operating mode control
// Assumes: Source requests are levels on CLK; pins are asynchronous
// Notes: RSTN acts as the power-on reset
// Function
// - Eight reset sources merged into one
// - One vector; status registers zero to two
// - Each source sets a readable sticky flag
// - Pin reset clears other flags and registers
// - Pin reset keeps warm flag and RTC
// - Low-speed internal oscillator after every reset
// - Software picks one of seven clock sources
// - Mode pins sampled only at reset release
// - Mode pin high single, low boot
// - Boot mode runs internal rewrite program
// - Single-chip: ROM on, external space off
// - ROM-enabled extended: ROM and external on
// - ROM-disabled extended: ROM off, external on
// - Two control bits choose operating mode
// - ROM enable cleared stays cleared until reset
// - ROM reprogram allowed in ROM-enabled modes
// - ROM-off extended mode address map decode
`timescale 1ns/1ps
module rcm_ctrl
  import rcm_pkg::*;
(
  input wire logic CLK,               // 100 MHz control clock
  input wire logic RSTN,              // Power-on reset, active low
  input wire logic CE,                // Clock enable
  input wire logic EXT_RESET_PIN_N,   // External reset pin, active low
  input wire logic MODE_PIN,          // Mode select pin
  input wire logic USB_BOOT_PIN,      // Boot interface select pin
  input wire logic VMON0_RST,         // Voltage monitor 0 reset request
  input wire logic VMON1_RST,         // Voltage monitor 1 reset request
  input wire logic VMON2_RST,         // Voltage monitor 2 reset request
  input wire logic INDEP_WDOG_RST,    // Independent watchdog reset request
  input wire logic WDOG_RST,          // Watchdog reset request
  input wire logic [7:0] ADDR,        // Register byte address
  input wire logic [31:0] WDATA,      // Write data
  input wire logic WR,                // Write strobe
  input wire logic RD,                // Read strobe
  input wire logic [31:0] CPU_ADDR,   // CPU address to classify
  output logic [31:0] RDATA,          // Read data, cycle after RD
  output logic CPU_RESET_N,           // CPU reset, active low
  output logic PERIPH_RESET_N,        // Peripheral register reset
  output logic [2:0] SYSCLK_SEL,      // System clock source
  output logic ROM_EN,                // On-chip ROM enabled
  output logic EXT_BUS_EN,            // External address space enabled
  output logic BOOT_MODE,             // Boot program running
  output logic BOOT_USB,              // Boot over USB, else serial 1
  output logic ROM_PROG_OK,           // User ROM rewrite allowed
  output logic [2:0] ADDR_REGION      // Decoded region of CPU_ADDR
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] pin_rst_s_q;
  logic [1:0] mode_s_q;
  logic [1:0] usb_s_q;
  logic [1:0] pin_rst_s_d;
  logic [1:0] mode_s_d;
  logic [1:0] usb_s_d;

  // Shift in; only stage 1 is read by logic
  always_comb
  begin
    pin_rst_s_d = {pin_rst_s_q[0], EXT_RESET_PIN_N};
    mode_s_d = {mode_s_q[0], MODE_PIN};
    usb_s_d = {usb_s_q[0], USB_BOOT_PIN};
  end

  // Reset to released pin so power-up does not look like a pin reset
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      pin_rst_s_q <= 2'b11;
      mode_s_q <= 2'b00;
      usb_s_q <= 2'b00;
    end
    else if (CE)
    begin
      pin_rst_s_q <= pin_rst_s_d;
      mode_s_q <= mode_s_d;
      usb_s_q <= usb_s_d;
    end
  end

  // ****************************************
  // Reset source merge
  // ****************************************
  typedef enum logic {SEQ_HOLD, SEQ_RUN} rcm_seq_t;
  rcm_seq_t seq_q;
  rcm_seq_t seq_d;
  logic [3:0] hold_q;
  logic [3:0] hold_d;
  logic sw_req_q;
  logic sw_req_d;
  logic pin_active;
  logic any_src;
  logic [NUM_SRC-1:0] src_vec;
  logic release_now;

  rcm_flag_if fl ();

  rcm_flag_bank u_flags (
    .CLK(CLK),
    .RSTN(RSTN),
    .CE(CE),
    .fl(fl.bank)
  );

  // All sources but power-on funnel into one hold request and one vector
  always_comb
  begin
    pin_active = !pin_rst_s_q[1];
    src_vec = '0;
    src_vec[FLG_VMON0] = VMON0_RST;
    src_vec[FLG_VMON1] = VMON1_RST;
    src_vec[FLG_VMON2] = VMON2_RST;
    src_vec[FLG_INDEP_WDOG] = INDEP_WDOG_RST;
    src_vec[FLG_WDOG] = WDOG_RST;
    src_vec[FLG_SOFTWARE] = sw_req_q;
    src_vec[FLG_EXT_PIN] = pin_active;
    any_src = |src_vec;
  end

  // Hold stretches every reset to a minimum width after the last source drops
  always_comb
  begin
    seq_d = seq_q;
    hold_d = hold_q;
    release_now = 1'b0;
    if (any_src)
    begin
      seq_d = SEQ_HOLD;
      hold_d = RST_HOLD_LOAD;
    end
    else if (seq_q == SEQ_HOLD)
    begin
      if (hold_q == 4'h0)
      begin
        seq_d = SEQ_RUN;
        release_now = 1'b1;
      end
      else
        hold_d = hold_q - 4'h1;
    end
  end

  // Power-on starts in hold so the pins get sampled at its release
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      seq_q <= SEQ_HOLD;
      hold_q <= RST_HOLD_LOAD;
    end
    else if (CE)
    begin
      seq_q <= seq_d;
      hold_q <= hold_d;
    end
  end

  // ****************************************
  // Register write side
  // ****************************************
  logic wr_sts0;
  logic wr_sts2;
  logic [NUM_SRC-1:0] clr_vec;

  // Flags are written one to clear
  always_comb
  begin
    wr_sts0 = WR && (ADDR == OFS_RST_STATUS_0) && (seq_q == SEQ_RUN);
    wr_sts2 = WR && (ADDR == OFS_RST_STATUS_2) && (seq_q == SEQ_RUN);
    clr_vec = '0;
    if (wr_sts0)
    begin
      clr_vec[FLG_POWER_ON] = WDATA[0];
      clr_vec[FLG_VMON0] = WDATA[1];
    end
    if (wr_sts2)
      clr_vec[NUM_SRC-1:FLG_VMON1] = WDATA[5:0];
    fl.set = src_vec;
    fl.clr = clr_vec;
    fl.pin_init = pin_active;
  end

  // ****************************************
  // Control registers
  // ****************************************
  logic rom_en_q;
  logic rom_en_d;
  logic ext_en_q;
  logic ext_en_d;
  rcm_clk_src_t clk_q;
  rcm_clk_src_t clk_d;
  logic boot_q;
  logic boot_d;
  logic usb_q;
  logic usb_d;
  logic warm_q;
  logic warm_d;
  logic [31:0] rtc_q;
  logic [31:0] rtc_d;
  logic wr_run;

  // Any reset restores defaults; warm flag and RTC only see power-on
  always_comb
  begin
    wr_run = WR && (seq_q == SEQ_RUN);
    rom_en_d = rom_en_q;
    ext_en_d = ext_en_q;
    clk_d = clk_q;
    boot_d = boot_q;
    usb_d = usb_q;
    warm_d = warm_q;
    rtc_d = rtc_q;
    sw_req_d = 1'b0;
    if (seq_q == SEQ_HOLD)
    begin
      rom_en_d = ROM_EN_RST;
      ext_en_d = EXT_BUS_RST;
      clk_d = CLK_LOW_INT_OSC;
      if (release_now)
      begin
        boot_d = !mode_s_q[1];
        usb_d = !mode_s_q[1] && usb_s_q[1];
      end
    end
    else if (wr_run)
    begin
      unique case (ADDR)
        OFS_SYS_CTRL_0:
        begin
          // Once cleared, a one write is ignored until the next reset
          rom_en_d = rom_en_q & WDATA[SC0_ROM_EN_BIT];
          ext_en_d = WDATA[SC0_EXT_BUS_BIT];
        end
        OFS_CLK_SELECT:
          // Codes past the last source are dropped; stabilisation is software's job
          if (WDATA[2:0] <= 3'(CLK_INDEP_WDOG_OSC))
            clk_d = rcm_clk_src_t'(WDATA[2:0]);
        OFS_RST_STATUS_1:
          warm_d = WDATA[STS1_WARM_BIT];
        OFS_SW_RESET:
          sw_req_d = WDATA[SWR_TRIGGER_BIT];
        OFS_RTC_KEEP:
          rtc_d = WDATA;
        default:
          sw_req_d = 1'b0;
      endcase
    end
  end

  // Control group, frozen while CE is low
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rom_en_q <= ROM_EN_RST;
      ext_en_q <= EXT_BUS_RST;
      clk_q <= CLK_LOW_INT_OSC;
      boot_q <= 1'b0;
      usb_q <= 1'b0;
      warm_q <= 1'b0;
      rtc_q <= RTC_KEEP_RST;
      sw_req_q <= 1'b0;
    end
    else if (CE)
    begin
      rom_en_q <= rom_en_d;
      ext_en_q <= ext_en_d;
      clk_q <= clk_d;
      boot_q <= boot_d;
      usb_q <= usb_d;
      warm_q <= warm_d;
      rtc_q <= rtc_d;
      sw_req_q <= sw_req_d;
    end
  end

  // ****************************************
  // Mode, decode and read data
  // ****************************************
  rcm_op_mode_t mode;
  rcm_region_t region_d;
  logic [31:0] rdata_d;
  logic prog_ok_d;

  // Mode from the two control bits; boot overrides ROM access
  always_comb
  begin
    mode = rcm_op_mode_t'({ext_en_q, rom_en_q});
    // Next-state terms keep permission and decode in step with ROM_EN and EXT_BUS_EN
    prog_ok_d = !boot_d && rom_en_d;
    region_d = REG_NONE;
    if (!rom_en_d && ext_en_d && !boot_d)
    begin
      if (CPU_ADDR < MAP_RAM_END)
        region_d = REG_RAM;
      else if (CPU_ADDR < MAP_PERIPH_BASE)
        region_d = REG_RESERVED;
      else if (CPU_ADDR < MAP_PERIPH_END)
        region_d = REG_PERIPH;
      else if (CPU_ADDR < MAP_CS_BASE)
        region_d = REG_RESERVED;
      else if (CPU_ADDR < MAP_RESV_BASE)
        region_d = REG_CS_EXT;
      else
        region_d = REG_RESERVED;
    end
    rdata_d = 32'h0000_0000;
    if (RD)
    begin
      unique case (ADDR)
        OFS_RST_STATUS_0: rdata_d = {30'h0, fl.flags[FLG_VMON0], fl.flags[FLG_POWER_ON]};
        OFS_RST_STATUS_1: rdata_d = {31'h0, warm_q};
        OFS_RST_STATUS_2: rdata_d = {26'h0, fl.flags[NUM_SRC-1:FLG_VMON1]};
        OFS_SYS_CTRL_0: rdata_d = {30'h0, ext_en_q, rom_en_q};
        OFS_CLK_SELECT: rdata_d = {29'h0, clk_q};
        OFS_MODE_STATUS: rdata_d = {28'h0, usb_q, boot_q, mode};
        OFS_RTC_KEEP: rdata_d = rtc_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Outputs all registered; boot mode keeps the external bus shut
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      RDATA <= 32'h0000_0000;
      CPU_RESET_N <= 1'b0;
      PERIPH_RESET_N <= 1'b0;
      SYSCLK_SEL <= 3'h0;
      ROM_EN <= 1'b0;
      EXT_BUS_EN <= 1'b0;
      BOOT_MODE <= 1'b0;
      BOOT_USB <= 1'b0;
      ROM_PROG_OK <= 1'b0;
      ADDR_REGION <= 3'h0;
    end
    else if (CE)
    begin
      RDATA <= rdata_d;
      CPU_RESET_N <= (seq_d == SEQ_RUN);
      PERIPH_RESET_N <= (seq_d == SEQ_RUN);
      SYSCLK_SEL <= clk_d;
      ROM_EN <= rom_en_d && !boot_d;
      EXT_BUS_EN <= ext_en_d && !boot_d;
      BOOT_MODE <= boot_d;
      BOOT_USB <= usb_d;
      ROM_PROG_OK <= prog_ok_d;
      ADDR_REGION <= region_d;
    end
  end

endmodule : rcm_ctrl

/* File: verification/rcm_board_model.sv */
// Purpose: Board side of the block: reset pin and mode jumpers
// Assumes: Requests come from the bench
// Notes: Pins move only just after a rising clock edge
`timescale 1ns/1ps
module rcm_board_model (
  input wire logic CLK, // Clock
  input wire logic hold_req, // Hold the reset pin low
  input wire logic mode_req, // Mode jumper level
  input wire logic usb_req, // Boot interface jumper level
  output logic EXT_RESET_PIN_N, // Reset pin, active low
  output logic MODE_PIN, // Mode pin
  output logic USB_BOOT_PIN // Boot select pin
);
  // ****************************************
  // Pin drivers
  // ****************************************
  logic [2:0] pins_q = 3'b110;
  // Jumpers are set with the pin held, so they are settled long before release
  always @(posedge CLK) pins_q <= {!hold_req, mode_req, usb_req};
  assign EXT_RESET_PIN_N = pins_q[2];
  assign MODE_PIN = pins_q[1];
  assign USB_BOOT_PIN = pins_q[0];
endmodule : rcm_board_model

/* File: verification/rcm_ctrl_monitor.sv */
// Purpose: Port-level checks of the reset, clock and mode block
// Assumes: One clock, RSTN asynchronous and active low
// Notes: Watches top-level ports only
`timescale 1ns/1ps
module rcm_ctrl_monitor
  import rcm_pkg::*;
(
  input wire logic CLK, // Clock
  input wire logic RSTN, // Reset, active low
  input wire logic VMON0_RST, // Voltage monitor request
  input wire logic WDOG_RST, // Watchdog request
  input wire logic [7:0] ADDR, // Register address
  input wire logic [31:0] WDATA, // Write data
  input wire logic WR, // Write strobe
  input wire logic RD, // Read strobe
  input wire logic [31:0] RDATA, // Read data
  input wire logic CPU_RESET_N, // CPU reset
  input wire logic PERIPH_RESET_N, // Peripheral reset
  input wire logic [2:0] SYSCLK_SEL, // Clock source
  input wire logic ROM_EN, // ROM enabled
  input wire logic EXT_BUS_EN, // External space enabled
  input wire logic BOOT_MODE, // Boot mode
  input wire logic ROM_PROG_OK, // ROM rewrite allowed
  input wire logic [2:0] ADDR_REGION // Decoded region
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RSTN);
  rd_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data seen outside answer cycle");
  src_hold_a: assert property ((WDOG_RST || VMON0_RST) |=> !CPU_RESET_N)
    else $error("cpu not held in reset");
  stretch_a: assert property ($fell(WDOG_RST) |-> (!CPU_RESET_N) [*8] ##[1:6] CPU_RESET_N)
    else $error("reset stretch length wrong");
  periph_a: assert property (PERIPH_RESET_N == CPU_RESET_N)
    else $error("peripheral reset differs from cpu reset");
  clk_low_a: assert property ($rose(CPU_RESET_N) |-> SYSCLK_SEL == 3'h0)
    else $error("clock not low-speed oscillator after reset");
  clk_wr_a: assert property ((WR && ADDR == OFS_CLK_SELECT && CPU_RESET_N && WDATA[2:0] != 3'h7)
    |=> SYSCLK_SEL == $past(WDATA[2:0])) else $error("clock select not taken");
  // Only while running: a hold forces the low-speed oscillator regardless of the code
  clk_bad_a: assert property ((WR && ADDR == OFS_CLK_SELECT && CPU_RESET_N && WDATA[2:0] == 3'h7)
    |=> $stable(SYSCLK_SEL)) else $error("illegal clock code taken");
  ext_wr_a: assert property ((WR && ADDR == OFS_SYS_CTRL_0 && CPU_RESET_N && !BOOT_MODE)
    |=> EXT_BUS_EN == $past(WDATA[SC0_EXT_BUS_BIT])) else $error("bus enable not taken");
  rom_stuck_a: assert property ((CPU_RESET_N && $past(CPU_RESET_N) && !$past(ROM_PROG_OK) && !BOOT_MODE)
    |-> !ROM_PROG_OK) else $error("rom enable set again");
  boot_off_a: assert property ((BOOT_MODE && $stable(BOOT_MODE))
    |-> !ROM_EN && !EXT_BUS_EN && !ROM_PROG_OK) else $error("boot mode left rom or bus on");
  prog_a: assert property (ROM_PROG_OK == ROM_EN)
    else $error("rom rewrite permission wrong");
  region_a: assert property ((ADDR_REGION != 3'h0 && CPU_RESET_N && $past(CPU_RESET_N))
    |-> !ROM_EN && !BOOT_MODE && EXT_BUS_EN) else $error("region decoded outside rom-off mode");
endmodule : rcm_ctrl_monitor

bind rcm_ctrl rcm_ctrl_monitor i_mon (.*);

/* File: verification/test_reset_clock_mode_control.sv */
// Purpose: Self-checking bench of the reset, clock and mode block
// Assumes: CE tied high; pins come from the board model
// Notes: Random values from a fixed-seed xorshift
`timescale 1ns/1ps
module test_reset_clock_mode_control;
  import rcm_pkg::*;
  logic CLK = 0, RSTN = 0, WR = 0, RD = 0, hold = 0, mode = 1, usb = 0;
  logic [4:0] src = 0; // vmon0, vmon1, vmon2, indep watchdog, watchdog
  logic [7:0] ADDR = 0;
  logic [31:0] WDATA = 0, CPU_ADDR = 0, RDATA, d, a, seed = 32'h8892F4C9;
  logic pin_n, mpin, upin, CPU_RESET_N, PERIPH_RESET_N, ROM_EN, EXT_BUS_EN, BOOT_MODE, BOOT_USB, ROM_PROG_OK;
  logic [2:0] SYSCLK_SEL, ADDR_REGION;
  logic [31:0] base [4] = '{32'h0, MAP_PERIPH_BASE, MAP_CS_BASE, MAP_RESV_BASE};
  int fails = 0, checked = 0;
  always #5 CLK = ~CLK;
  rcm_board_model i_board (.CLK(CLK), .hold_req(hold), .mode_req(mode), .usb_req(usb),
    .EXT_RESET_PIN_N(pin_n), .MODE_PIN(mpin), .USB_BOOT_PIN(upin));
  rcm_ctrl i_dut (.CE(1'b1), .EXT_RESET_PIN_N(pin_n), .MODE_PIN(mpin), .USB_BOOT_PIN(upin),
    .VMON0_RST(src[0]), .VMON1_RST(src[1]), .VMON2_RST(src[2]), .INDEP_WDOG_RST(src[3]), .WDOG_RST(src[4]), .*);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Gaps between regions fall through to the reserved code 4; the test addresses never land in them
  function automatic logic [31:0] exp_region(logic [31:0] x);
    if (x < MAP_RAM_END) return 32'h1;
    if (x >= MAP_PERIPH_BASE && x < MAP_PERIPH_END) return 32'h2;
    if (x >= MAP_CS_BASE && x < MAP_RESV_BASE) return 32'h3;
    return 32'h4;
  endfunction : exp_region
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(logic [7:0] ad, logic [31:0] v);
    @(posedge CLK);
    ADDR <= ad;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    #1;
  endtask : wr
  task automatic rdc(logic [7:0] ad, logic [31:0] e, string n);
    @(posedge CLK);
    ADDR <= ad;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(n, RDATA, e);
  endtask : rdc
  // Bounded wait for the CPU to leave reset, sampled mid-cycle
  task automatic run();
    for (int n = 0; n < 80 && CPU_RESET_N !== 1'b1; n++) @(negedge CLK);
    chk("cpu running", CPU_RESET_N, 1'b1);
  endtask : run
  task automatic stop_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  initial
  begin
    #100000;
    fails++;
    stop_test();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    repeat (12) @(posedge CLK);
    RSTN <= 1'b1;
    run();
    rdc(OFS_RST_STATUS_0, 32'h1, "power flag");
    rdc(OFS_MODE_STATUS, 32'h1, "single mode");
    chk("clock", SYSCLK_SEL, 32'h0);
    wr(8'h20, 32'hFFFFFFFF);
    rdc(8'h20, 32'h0, "unmapped");
    $display("test reset done");
    // Monitor, watchdog and software sources in turn, clock moved off the low-speed oscillator first
    for (int i = 0; i < 6; i++)
    begin
      wr(OFS_CLK_SELECT, i + 1);
      chk("clock", SYSCLK_SEL, i + 1);
      wr(OFS_CLK_SELECT, 32'h7);
      chk("clock kept", SYSCLK_SEL, i + 1);
      d = (i == 0) ? 32'h2 : (32'h1 << (i - 1));
      a = (i == 0) ? OFS_RST_STATUS_0 : OFS_RST_STATUS_2;
      if (i == 5) wr(OFS_SW_RESET, 32'h1);
      else
      begin
        @(posedge CLK);
        src[i] <= 1'b1;
        repeat (1 + rnd() % 4) @(posedge CLK);
        src[i] <= 1'b0;
      end
      repeat (3) @(posedge CLK);
      #1 chk("held", CPU_RESET_N, 32'h0);
      run();
      chk("clock", SYSCLK_SEL, 32'h0);
      rdc(a[7:0], d | (i == 0), "flag");
      wr(a[7:0], d);
      rdc(a[7:0], i == 0, "flag cleared");
    end
    $display("test sources done");
    wr(OFS_SYS_CTRL_0, 32'h3);
    rdc(OFS_MODE_STATUS, 32'h3, "rom ext mode");
    wr(OFS_SYS_CTRL_0, 32'h2);
    rdc(OFS_MODE_STATUS, 32'h2, "rom off mode");
    for (int k = 0; k < 16; k++)
    begin
      a = base[k % 4] + (rnd() & ((k < 4) ? 32'h0 : 32'hFFFF));
      @(posedge CLK);
      CPU_ADDR <= a;
      @(posedge CLK);
      #1 chk("region", ADDR_REGION, exp_region(a));
    end
    // ROM off and bus off: the fourth code, with no decode behind it
    wr(OFS_SYS_CTRL_0, 32'h0);
    rdc(OFS_MODE_STATUS, 32'h0, "no ext mode");
    chk("region off", ADDR_REGION, 32'h0);
    wr(OFS_SYS_CTRL_0, 32'h3);
    chk("rom stuck", ROM_EN, 32'h0);
    chk("ext", EXT_BUS_EN, 32'h1);
    $display("test modes done");
    d = rnd();
    wr(OFS_RTC_KEEP, d);
    wr(OFS_RST_STATUS_1, 32'h1);
    // Pin resets with USB boot, serial boot, then single mode
    for (int k = 0; k < 3; k++)
    begin
      @(posedge CLK);
      hold <= 1'b1;
      mode <= (k == 2);
      usb <= (k == 0);
      repeat (20) @(posedge CLK);
      hold <= 1'b0;
      run();
      mode <= (k != 2);
      repeat (5) @(posedge CLK);
      #1 chk("boot", BOOT_MODE, k != 2);
      chk("usb boot", BOOT_USB, k == 0);
    end
    chk("rom", ROM_EN, 32'h1);
    chk("ext", EXT_BUS_EN, 32'h0);
    chk("region", ADDR_REGION, 32'h0);
    rdc(OFS_RTC_KEEP, d, "rtc");
    rdc(OFS_RST_STATUS_1, 32'h1, "warm");
    rdc(OFS_RST_STATUS_0, 32'h0, "power flag");
    rdc(OFS_RST_STATUS_2, 32'h20, "pin flag");
    $display("test pins done");
    stop_test();
  end
endmodule : test_reset_clock_mode_control
